/* File: common/loss_boost_pkg.sv */
// Package of register offsets, field layouts and constants for the loss/boost flag block.
package loss_boost_pkg;

	// Output function codes selectable on the assignable outputs.
	localparam logic [7:0] FUNC_SIGNAL_LOSS = 8'h06;
	localparam logic [7:0] FUNC_BOOST       = 8'h07;

	// Current input span in microamps.
	localparam logic [15:0] CUR_SPAN_LOW_UA  = 16'h0FA0;
	localparam logic [15:0] CUR_SPAN_HIGH_UA = 16'h4E20;

	// Register byte offsets.
	localparam logic [7:0] REG_CTRL      = 8'h00;
	localparam logic [7:0] REG_THRESH    = 8'h04;
	localparam logic [7:0] REG_LIMITS    = 8'h08;
	localparam logic [7:0] REG_SEL       = 8'h0C;
	localparam logic [7:0] REG_STATUS    = 8'h10;
	localparam logic [7:0] REG_IRQSTAT   = 8'h14;
	localparam logic [7:0] REG_IRQMASK   = 8'h18;
	localparam logic [7:0] REG_CURSCALED = 8'h1C;

	// Control register fields.
	localparam int CTRL_RUN_BIT  = 0;
	localparam int CTRL_DECEL_BIT = 1;

	// Field positions inside the packed limit and selection registers.
	localparam int LIM_LOW_LSB  = 0;
	localparam int LIM_HIGH_LSB = 8;
	localparam int SEL_OC_LSB   = 0;
	localparam int SEL_RLY_LSB  = 8;

	// Status and interrupt bit positions.
	localparam int ST_LOSS_BIT  = 0;
	localparam int ST_BOOST_BIT = 1;
	localparam int ST_VLOSS_BIT = 2;
	localparam int ST_ILOSS_BIT = 3;
	localparam int ST_STOP_BIT  = 4;
	localparam int IRQ_W        = 4;
	localparam int IRQ_LOSS_ON  = 0;
	localparam int IRQ_LOSS_OFF = 1;
	localparam int IRQ_BOOST_ON = 2;
	localparam int IRQ_BOOST_OFF = 3;

	// Reset values.
	localparam logic [7:0]  RST_THRESH = 8'h00;
	localparam logic [7:0]  RST_LOW    = 8'h00;
	localparam logic [7:0]  RST_HIGH   = 8'h64;
	localparam logic [7:0]  RST_SEL_OC = 8'h00;
	localparam logic [7:0]  RST_SEL_RLY = 8'h00;

	// Full scale in percent.
	localparam logic [7:0]  PCT_FULL = 8'h64;

	// AXI4-Lite response codes.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* File: logic/pct_compare.sv */
// Hysteresis comparator that drives the second-stage boost flag.
`timescale 1ns/1ps
module pct_compare
	import loss_boost_pkg::*;
(
	// Clock and reset.
	input  wire logic       clk_sys,
	input  wire logic       rst_b,
	// Run state and process variable in percent.
	input  wire logic       running,
	input  wire logic [7:0] pvPct,
	input  wire logic [7:0] lowPct,
	input  wire logic [7:0] highPct,
	// Boost flag.
	output logic            boost
);

	// All state of the comparator.
	typedef struct packed {
		logic boost;
	} cmp_state_t;

	cmp_state_t state_ff;
	cmp_state_t nxt_state;

	// Next-state logic: set below low, clear above high, hold between.
	always_comb begin
		nxt_state = state_ff;
		if (!running) begin
			nxt_state.boost = 1'b0;
		end else if (pvPct < lowPct) begin
			nxt_state.boost = 1'b1;
		end else if (pvPct > highPct) begin
			nxt_state.boost = 1'b0;
		end
	end

	// State register, cleared on reset.
	// Reset clears flag.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Flag comes straight from the register.
	assign boost = state_ff.boost;

endmodule

/* File: logic/loss_boost_flags.sv */
// Signal-loss and second-stage boost flag block with AXI4-Lite registers.
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Loss flag when voltage below start threshold
// - Loss flag when current under 4mA
// - Current input scaled over 4-20mA span
// - Loss flag clears itself on recovery
// - Loss never trips nor latches errors
// - Loss commands decel to stop
// - Loss flag is output code 06
// - Boost flag is output code 07
// - Running, process variable below low: boost on
// - Process variable above high: boost off
// - Between limits boost holds its state
// - Stop mode forces boost off
// - Compare values in percent of scale
// - Boost off on stop, on only running
module loss_boost_flags
	import loss_boost_pkg::*;
#(
	parameter int ADDR_W = 8
)
(
	// Clock and reset.
	input  wire logic              clk_sys,
	input  wire logic              rst_b,
	// Converted analog inputs and run command from pins.
	input  wire logic [7:0]        voltRefPct,
	input  wire logic [15:0]       currentSpeedRefIn,
	input  wire logic [7:0]        processVariable,
	input  wire logic [7:0]        controlSetpoint,
	input  wire logic              forwardRunCmd,
	// Assignable outputs and flags.
	output logic                   signalLossFlag,
	output logic                   secondStageBoostFlag,
	output logic                   openCollectorOut,
	output logic                   relayOut,
	output logic                   decelToStop,
	output logic                   irq,
	// AXI4-Lite write address.
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	// AXI4-Lite write data.
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	// AXI4-Lite write response.
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	output logic [1:0]             s_axi_bresp,
	// AXI4-Lite read address.
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	// AXI4-Lite read data.
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp
);

	//////////////////////////////////////////////////////////////////////////
	// State.

	// All registered state of the block except the boost flag, which u_cmp holds.
	typedef struct packed {
		// Two-stage synchronisers for pin inputs.
		logic [7:0]          voltS1;
		logic [7:0]          voltS2;
		logic [15:0]         curS1;
		logic [15:0]         curS2;
		logic [7:0]          pvS1;
		logic [7:0]          pvS2;
		logic [7:0]          spS1;
		logic [7:0]          spS2;
		logic                runS1;
		logic                runS2;
		// Software-written configuration and the sticky interrupt status.
		logic                swRun;
		logic                decelEn;
		logic [7:0]          thresh;
		logic [7:0]          lowLim;
		logic [7:0]          highLim;
		logic [7:0]          selOc;
		logic [7:0]          selRly;
		logic [IRQ_W-1:0]    irqMask;
		logic [IRQ_W-1:0]    irqStat;
		// Flags and outputs.
		logic                loss;
		logic                vLoss;
		logic                iLoss;
		logic [7:0]          curPct;
		logic                ocOut;
		logic                rlyOut;
		logic                decel;
		logic                irq;
		logic                boostPrev;
		// Bus slave state.
		logic                awHave;
		logic [ADDR_W-1:0]   awAddr;
		logic                wHave;
		logic [31:0]         wData;
		logic [3:0]          wStrb;
		logic                bValid;
		logic [1:0]          bResp;
		logic                rValid;
		logic [31:0]         rData;
		logic [1:0]          rResp;
	} blk_state_t;

	blk_state_t state_ff;
	blk_state_t nxt_state;
	logic       boost;
	logic       running;

	// Byte-lane merge of a write into an 8-bit field at a bit offset.
	function automatic logic [7:0] lane8(input logic [7:0] old, input logic [31:0] d,
		input logic [3:0] s, input int lsb);
		lane8 = s[lsb/8] ? d[lsb +: 8] : old;
	endfunction

	// Scale a 4-20mA reading in microamps to percent of the span.
	function automatic logic [7:0] scaleCur(input logic [15:0] ua);
		logic [31:0] num;
		num = 32'h0;
		if (ua <= CUR_SPAN_LOW_UA) begin
			scaleCur = 8'h00;
		end else if (ua >= CUR_SPAN_HIGH_UA) begin
			scaleCur = PCT_FULL;
		end else begin
			num = 32'(ua - CUR_SPAN_LOW_UA) * 32'(PCT_FULL);
			scaleCur = 8'(num / 32'(CUR_SPAN_HIGH_UA - CUR_SPAN_LOW_UA));
		end
	endfunction

	// Map an output function code to the flag it carries.
	function automatic logic pickFunc(input logic [7:0] code, input logic loss,
		input logic bst);
		if (code == FUNC_SIGNAL_LOSS) begin
			pickFunc = loss;
		end else if (code == FUNC_BOOST) begin
			pickFunc = bst;
		end else begin
			pickFunc = 1'b0;
		end
	endfunction

	//////////////////////////////////////////////////////////////////////////
	// Boost comparator.

	assign running = state_ff.runS2 & state_ff.swRun;

	pct_compare u_cmp (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.running (running),
		.pvPct   (state_ff.pvS2),
		.lowPct  (state_ff.lowLim),
		.highPct (state_ff.highLim),
		.boost   (boost)
	);

	//////////////////////////////////////////////////////////////////////////
	// Next-state logic.

	// Computes flags, outputs and the bus slave each cycle.
	always_comb begin
		logic       wrFire;
		logic       rdFire;
		logic       vl;
		logic       il;
		logic       lossNow;
		logic [IRQ_W-1:0] ev;
		logic [IRQ_W-1:0] clr;
		wrFire = 1'b0;
		rdFire = 1'b0;
		vl = 1'b0;
		il = 1'b0;
		lossNow = 1'b0;
		ev = '0;
		clr = '0;
		nxt_state = state_ff;

		// Synchronise pin inputs through two flops.
		nxt_state.voltS1 = voltRefPct;
		nxt_state.voltS2 = state_ff.voltS1;
		nxt_state.curS1 = currentSpeedRefIn;
		nxt_state.curS2 = state_ff.curS1;
		nxt_state.pvS1 = processVariable;
		nxt_state.pvS2 = state_ff.pvS1;
		nxt_state.spS1 = controlSetpoint;
		nxt_state.spS2 = state_ff.spS1;
		nxt_state.runS1 = forwardRunCmd;
		nxt_state.runS2 = state_ff.runS1;

		nxt_state.curPct = scaleCur(state_ff.curS2);

		vl = state_ff.voltS2 < state_ff.thresh;
		il = state_ff.curS2 < CUR_SPAN_LOW_UA;
		lossNow = vl | il;
		nxt_state.vLoss = vl;
		nxt_state.iLoss = il;
		nxt_state.loss = lossNow;

		nxt_state.decel = lossNow & state_ff.decelEn;

		nxt_state.ocOut = pickFunc(state_ff.selOc, state_ff.loss, boost);
		nxt_state.rlyOut = pickFunc(state_ff.selRly, state_ff.loss, boost);

		// Edge events of both flags.
		nxt_state.boostPrev = boost;
		ev[IRQ_LOSS_ON] = lossNow & ~state_ff.loss;
		ev[IRQ_LOSS_OFF] = ~lossNow & state_ff.loss;
		ev[IRQ_BOOST_ON] = boost & ~state_ff.boostPrev;
		ev[IRQ_BOOST_OFF] = ~boost & state_ff.boostPrev;

		// Write channel capture.
		if (s_axi_awvalid && !state_ff.awHave) begin
			nxt_state.awHave = 1'b1;
			nxt_state.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !state_ff.wHave) begin
			nxt_state.wHave = 1'b1;
			nxt_state.wData = s_axi_wdata;
			nxt_state.wStrb = s_axi_wstrb;
		end
		wrFire = state_ff.awHave & state_ff.wHave & ~state_ff.bValid;
		if (wrFire) begin
			nxt_state.awHave = 1'b0;
			nxt_state.wHave = 1'b0;
			nxt_state.bValid = 1'b1;
			nxt_state.bResp = RESP_OKAY;
			unique case (state_ff.awAddr)
				REG_CTRL: begin
					if (state_ff.wStrb[0]) begin
						nxt_state.swRun = state_ff.wData[CTRL_RUN_BIT];
						nxt_state.decelEn = state_ff.wData[CTRL_DECEL_BIT];
					end
				end
				REG_THRESH: begin
					nxt_state.thresh = lane8(state_ff.thresh, state_ff.wData,
						state_ff.wStrb, 0);
				end
				REG_LIMITS: begin
					nxt_state.lowLim = lane8(state_ff.lowLim, state_ff.wData,
						state_ff.wStrb, LIM_LOW_LSB);
					nxt_state.highLim = lane8(state_ff.highLim, state_ff.wData,
						state_ff.wStrb, LIM_HIGH_LSB);
				end
				REG_SEL: begin
					nxt_state.selOc = lane8(state_ff.selOc, state_ff.wData,
						state_ff.wStrb, SEL_OC_LSB);
					nxt_state.selRly = lane8(state_ff.selRly, state_ff.wData,
						state_ff.wStrb, SEL_RLY_LSB);
				end
				REG_IRQMASK: begin
					if (state_ff.wStrb[0]) begin
						nxt_state.irqMask = state_ff.wData[IRQ_W-1:0];
					end
				end
				REG_STATUS, REG_IRQSTAT, REG_CURSCALED: begin
					// Read-only registers ignore writes.
				end
				default: begin
					nxt_state.bResp = RESP_SLVERR;
				end
			endcase
		end
		if (state_ff.bValid && s_axi_bready) begin
			nxt_state.bValid = 1'b0;
		end

		// Read channel.
		rdFire = s_axi_arvalid & ~state_ff.rValid;
		if (rdFire) begin
			nxt_state.rValid = 1'b1;
			nxt_state.rResp = RESP_OKAY;
			nxt_state.rData = 32'h0;
			unique case (s_axi_araddr)
				REG_CTRL: begin
					nxt_state.rData[CTRL_RUN_BIT] = state_ff.swRun;
					nxt_state.rData[CTRL_DECEL_BIT] = state_ff.decelEn;
				end
				REG_THRESH: begin
					nxt_state.rData[7:0] = state_ff.thresh;
				end
				REG_LIMITS: begin
					nxt_state.rData[LIM_LOW_LSB +: 8] = state_ff.lowLim;
					nxt_state.rData[LIM_HIGH_LSB +: 8] = state_ff.highLim;
				end
				REG_SEL: begin
					nxt_state.rData[SEL_OC_LSB +: 8] = state_ff.selOc;
					nxt_state.rData[SEL_RLY_LSB +: 8] = state_ff.selRly;
				end
				REG_STATUS: begin
					nxt_state.rData[ST_LOSS_BIT] = state_ff.loss;
					nxt_state.rData[ST_BOOST_BIT] = boost;
					nxt_state.rData[ST_VLOSS_BIT] = state_ff.vLoss;
					nxt_state.rData[ST_ILOSS_BIT] = state_ff.iLoss;
					nxt_state.rData[ST_STOP_BIT] = ~running;
				end
				REG_IRQSTAT: begin
					// A read clears what it returned.
					nxt_state.rData[IRQ_W-1:0] = state_ff.irqStat;
					clr = state_ff.irqStat;
				end
				REG_IRQMASK: begin
					nxt_state.rData[IRQ_W-1:0] = state_ff.irqMask;
				end
				REG_CURSCALED: begin
					nxt_state.rData[7:0] = state_ff.curPct;
				end
				default: begin
					nxt_state.rResp = RESP_SLVERR;
				end
			endcase
		end
		if (state_ff.rValid && s_axi_rready) begin
			nxt_state.rValid = 1'b0;
		end

		// Sticky status: a new event wins over a read clear.
		nxt_state.irqStat = (state_ff.irqStat & ~clr) | ev;
		nxt_state.irq = |(nxt_state.irqStat & state_ff.irqMask);
	end

	//////////////////////////////////////////////////////////////////////////
	// State register.

	// Synchronous active-low reset to documented defaults.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			state_ff <= '0;
			state_ff.thresh <= RST_THRESH;
			state_ff.lowLim <= RST_LOW;
			state_ff.highLim <= RST_HIGH;
			state_ff.selOc <= RST_SEL_OC;
			state_ff.selRly <= RST_SEL_RLY;
			state_ff.swRun <= 1'b1;
			state_ff.decelEn <= 1'b1;
		end else begin
			state_ff <= nxt_state;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Outputs, each from a flip-flop.

	assign signalLossFlag = state_ff.loss;
	assign secondStageBoostFlag = boost;
	assign openCollectorOut = state_ff.ocOut;
	assign relayOut = state_ff.rlyOut;
	assign decelToStop = state_ff.decel;
	assign irq = state_ff.irq;
	assign s_axi_awready = ~state_ff.awHave;
	assign s_axi_wready = ~state_ff.wHave;
	assign s_axi_bvalid = state_ff.bValid;
	assign s_axi_bresp = state_ff.bResp;
	assign s_axi_arready = ~state_ff.rValid;
	assign s_axi_rvalid = state_ff.rValid;
	assign s_axi_rdata = state_ff.rData;
	assign s_axi_rresp = state_ff.rResp;

endmodule

/* File: verification/loss_boost_flags_props.sv */
// Concurrent checks on the ports of the loss and boost flag block.
`timescale 1ns/1ps
module loss_boost_flags_props
	import loss_boost_pkg::*;
(
	// Clock and reset.
	input wire logic        clk_sys,
	input wire logic        rst_b,
	// Pin inputs.
	input wire logic [7:0]  voltRefPct,
	input wire logic [15:0] currentSpeedRefIn,
	input wire logic        forwardRunCmd,
	// Flag outputs.
	input wire logic        signalLossFlag,
	input wire logic        secondStageBoostFlag,
	input wire logic        openCollectorOut,
	input wire logic        relayOut,
	input wire logic        decelToStop,
	// Bus handshakes.
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata
);
	// One clock domain, reset disables every check.
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	//////////////////////////////////////////////////////////////////////////////
	// Named steps of the behaviours.
	sequence curLow;
		(currentSpeedRefIn < CUR_SPAN_LOW_UA)[*4];
	endsequence
	sequence inputsGood;
		(currentSpeedRefIn >= CUR_SPAN_LOW_UA && voltRefPct == 8'hFF)[*4];
	endsequence
	sequence writeTaken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence readTaken;
		s_axi_arvalid && s_axi_arready;
	endsequence

	//////////////////////////////////////////////////////////////////////////////
	// Assertions.
	a_loss_cur_low: assert property (curLow |=> signalLossFlag)
		else $error("loss flag missing under low current");
	a_loss_self_clear: assert property (inputsGood |=> !signalLossFlag)
		else $error("loss flag stuck after recovery");
	a_boost_stop_off: assert property ((!forwardRunCmd)[*5] |=> !secondStageBoostFlag)
		else $error("boost flag on while stopped");
	a_boost_needs_run: assert property ($rose(secondStageBoostFlag) |->
		$past(forwardRunCmd, 3))
		else $error("boost flag rose without run");
	a_oc_source: assert property (openCollectorOut |->
		$past(signalLossFlag) || $past(secondStageBoostFlag))
		else $error("open collector high without source");
	a_relay_source: assert property (relayOut |->
		$past(signalLossFlag) || $past(secondStageBoostFlag))
		else $error("relay high without source");
	a_decel_cause: assert property (decelToStop |-> signalLossFlag || $past(signalLossFlag))
		else $error("decel without loss");
	a_write_answer: assert property (writeTaken |-> ##[1:3] s_axi_bvalid)
		else $error("write response missing");
	a_read_answer: assert property (readTaken |=> s_axi_rvalid)
		else $error("read response late");
	a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
endmodule

bind loss_boost_flags loss_boost_flags_props u_props (.clk_sys, .rst_b, .voltRefPct,
	.currentSpeedRefIn, .forwardRunCmd, .signalLossFlag, .secondStageBoostFlag,
	.openCollectorOut, .relayOut, .decelToStop, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

/* File: verification/terminal_reader.sv */
// Model of an outside device reading the two assignable output terminals.
`timescale 1ns/1ps
module terminal_reader
(
	// Clock.
	input  wire logic clk_sys,
	// Terminals driven by the block.
	input  wire logic openCollectorOut,
	input  wire logic relayOut,
	// Levels the device has read.
	output logic      ocSeen,
	output logic      relaySeen
);
	// Latch the terminal levels once per clock.
	always_ff @(posedge clk_sys) begin
		ocSeen    <= openCollectorOut;
		relaySeen <= relayOut;
	end
endmodule

/* File: verification/testbench.sv */
// Self-checking testbench for the loss and boost flag block.
`timescale 1ns/1ps
module testbench;
	import loss_boost_pkg::*;
	logic        clk_sys, rst_b, fwd, awv, wv, bRdy, arv, rRdy, strb;
	logic [7:0]  volt, pv, awa, ara, thr;
	logic [15:0] cur;
	logic [31:0] wd, d;
	logic [1:0]  r, bresp, rresp;
	logic        loss, boost, oc, rly, decel, irq, awRdy, wRdy, bv, arRdy, rv, ocSeen, rlySeen, eb;
	logic [31:0] rdata;
	int          miscompares = 0, num_checks = 0, cycles = 0;
	// Corner tables: inputs for the loss path and steps of the boost path.
	logic [7:0]  cv[4] = '{8'h1F, 8'h20, 8'hFF, 8'hFF};
	logic [15:0] cc[4] = '{16'h4E20, 16'h0FA0, 16'h0F9F, 16'h0FA0};
	logic [7:0]  bp[8] = '{8'h0A, 8'h32, 8'h46, 8'h47, 8'h1E, 8'h14, 8'h32, 8'h32};

	loss_boost_flags u_loss_boost_flags (.clk_sys, .rst_b, .voltRefPct(volt),
		.currentSpeedRefIn(cur), .processVariable(pv), .controlSetpoint(pv),
		.forwardRunCmd(fwd), .signalLossFlag(loss), .secondStageBoostFlag(boost),
		.openCollectorOut(oc), .relayOut(rly), .decelToStop(decel), .irq,
		.s_axi_awvalid(awv), .s_axi_awready(awRdy), .s_axi_awaddr(awa),
		.s_axi_wvalid(wv), .s_axi_wready(wRdy), .s_axi_wdata(wd), .s_axi_wstrb({4{strb}}),
		.s_axi_bvalid(bv), .s_axi_bready(bRdy), .s_axi_bresp(bresp),
		.s_axi_arvalid(arv), .s_axi_arready(arRdy), .s_axi_araddr(ara),
		.s_axi_rvalid(rv), .s_axi_rready(rRdy), .s_axi_rdata(rdata), .s_axi_rresp(rresp));
	terminal_reader u_terminal_reader (.clk_sys, .openCollectorOut(oc), .relayOut(rly),
		.ocSeen, .relaySeen(rlySeen));

	// Clock of 5 ns and a hang limit.
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			wrap_up();
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Compare, bus and closing tasks.
	task automatic chk_flag(input logic g, input logic e);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value at %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value at %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic ad, dd;
		ad = 0;
		dd = 0;
		@(posedge clk_sys);
		awv <= 1'b1; wv <= 1'b1; awa <= a; wd <= v; bRdy <= 1'b1;
		while (!(ad && dd)) begin
			@(posedge clk_sys);
			if (!ad && awRdy) begin ad = 1; awv <= 1'b0; end
			if (!dd && wRdy) begin dd = 1; wv <= 1'b0; end
		end
		do @(posedge clk_sys); while (!bv);
		r = bresp;
		bRdy <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys);
		arv <= 1'b1; ara <= a;
		do @(posedge clk_sys); while (!arRdy);
		arv <= 1'b0;
		do @(posedge clk_sys); while (!rv);
		rRdy <= 1'b1;
		@(posedge clk_sys);
		d = rdata; r = rresp; rRdy <= 1'b0;
	endtask
	task automatic settle();
		repeat (7) @(posedge clk_sys);
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Expected flags worked out from the limits and thresholds.
	function automatic logic exp_loss(logic [7:0] v, logic [7:0] t, logic [15:0] c);
		return (v < t) || (c < CUR_SPAN_LOW_UA);
	endfunction
	function automatic logic exp_boost(logic run, logic [7:0] p, logic prev);
		if (!run) return 1'b0;
		if (p < 8'h1E) return 1'b1;
		if (p > 8'h46) return 1'b0;
		return prev;
	endfunction

	//////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		void'($urandom(47));
		rst_b = 0; fwd = 0; awv = 0; wv = 0; bRdy = 0; arv = 0; rRdy = 0; strb = 1;
		volt = 8'hFF; cur = 16'h4E20; pv = 8'h32; awa = 0; ara = 0; wd = 0; eb = 0;
		repeat (4) @(posedge clk_sys);
		rst_b <= 1'b1;
		// Reset values, then an unmapped read and an unmapped write.
		rd(REG_CTRL); chk_reg(d, 32'h3);
		rd(REG_LIMITS); chk_reg(d, 32'h6400);
		rd(REG_IRQMASK); chk_reg(d, 32'h0);
		rd(8'h20);
		chk_reg(d, 32'h0);
		chk_reg(32'(r), 32'(RESP_SLVERR));
		wr(8'h24, 32'hFF);
		chk_reg(32'(r), 32'(RESP_SLVERR));
		wr(REG_SEL, 32'({FUNC_BOOST, FUNC_SIGNAL_LOSS}));
		thr = 8'h20;
		wr(REG_THRESH, 32'(thr));
		// Loss path: corners first, then random inputs.
		for (int i = 0; i < 20; i++) begin
			volt <= (i < 4) ? cv[i] : 8'($urandom_range(0, 255));
			cur <= (i < 4) ? cc[i] : 16'($urandom_range(3000, 21000));
			settle();
			chk_flag(loss, exp_loss(volt, thr, cur));
			chk_flag(decel, exp_loss(volt, thr, cur));
			chk_flag(ocSeen, exp_loss(volt, thr, cur));
		end
		// With decel disabled a loss still flags but stops nothing.
		volt <= 8'h00;
		wr(REG_CTRL, 32'h1);
		settle();
		chk_flag(loss, 1'b1);
		chk_flag(decel, 1'b0);
		wr(REG_CTRL, 32'h3);
		volt <= 8'hFF; cur <= 16'h4E20;
		wr(REG_LIMITS, 32'h461E);
		rd(REG_CURSCALED); chk_reg(d, 32'(PCT_FULL));
		// Boost path: hysteresis steps, stop, then random steps.
		for (int i = 0; i < 20; i++) begin
			// Forward run command opens the run state.
			fwd <= (i < 8) ? (i != 7) : ($urandom_range(0, 3) != 0);
			pv <= (i < 8) ? bp[i] : 8'($urandom_range(0, 100));
			settle();
			eb = exp_boost(fwd, pv, eb);
			chk_flag(boost, eb);
			chk_flag(rlySeen, eb);
		end
		// Interrupt raised, read back, cleared and masked.
		fwd <= 1'b0; pv <= 8'h14; wr(REG_IRQMASK, 32'hF);
		settle(); rd(REG_IRQSTAT); settle();
		chk_flag(irq, 1'b0);
		fwd <= 1'b1; settle();
		chk_flag(irq, 1'b1);
		rd(REG_STATUS); chk_reg(d, 32'h2);
		rd(REG_IRQSTAT); chk_reg(d, 32'h4);
		settle(); chk_flag(irq, 1'b0);
		wr(REG_IRQMASK, 32'h0); fwd <= 1'b0; settle();
		chk_flag(irq, 1'b0);
		rd(REG_IRQSTAT); chk_reg(d, 32'h8);
		wr(REG_SEL, 32'h0605); settle();
		chk_flag(ocSeen, 1'b0);
		// Mid-span current: 12 mA reads as half of full scale.
		cur <= 16'h2EE0;
		settle();
		rd(REG_CURSCALED); chk_reg(d, 32'h32);
		wrap_up();
	end
endmodule
